// File: brfsp_pkg.sv
package brfsp_pkg;
   // storage geometry
   localparam int NUM_BANKS      = 8;
   localparam int REGS_PER_BANK  = 16;
   localparam int BANK_W         = 3;
   localparam int REG_W          = 4;
   localparam int RAM_IDX_W      = BANK_W + REG_W;
   localparam int ADDR_W         = 24;

   // register window in data memory
   localparam logic [23:0] GPR_WINDOW_BASE  = 24'h00fe80;
   localparam logic [23:0] GPR_WINDOW_LAST  = 24'h00feff;
   localparam logic [23:0] HIGH_MAP_OFFSET  = 24'h0f0000;
   localparam int          WINDOW_LSB_W     = RAM_IDX_W;

   // absolute 8-bit register numbers
   localparam logic [3:0] REG_X        = 4'h0;
   localparam logic [3:0] REG_A        = 4'h1;
   localparam logic [3:0] REG_C        = 4'h2;
   localparam logic [3:0] REG_B        = 4'h3;
   localparam logic [3:0] LEGACY_SHIFT = 4'h4;
   localparam logic [3:0] REG_E        = 4'hc;

   // absolute 16-bit pair numbers
   localparam logic [2:0] PAIR_AX       = 3'h0;
   localparam logic [2:0] PAIR_BC       = 3'h1;
   localparam logic [2:0] PAIR_PC_LOW   = 3'h2;
   localparam logic [2:0] PAIR_PC_HIGH  = 3'h3;
   localparam logic [2:0] PAIR_PTR_BASE = 3'h4;
   localparam logic [2:0] PAIR_DE       = 3'h6;
   localparam logic [2:0] PAIR_HL       = 3'h7;

   // 24-bit pointer numbers (pointer k uses pair 4+k and extension k)
   localparam logic [1:0] PTR_BASE     = 2'h0;
   localparam logic [1:0] PTR_USTACK   = 2'h1;
   localparam logic [1:0] PTR_STR_ONE  = 2'h2;
   localparam logic [1:0] PTR_STR_TWO  = 2'h3;

   // status word field positions
   localparam int PSW_RSS_BIT     = 5;
   localparam int PSW_BANK_LSB    = 12;
   localparam int PSW_BANK_MSB    = 14;
   localparam int PSW_SAVE_HI_LSB = 12;
   localparam int PSW_SAVE_LO_MSB = 7;

   // reset values
   localparam logic [2:0]  BANK_RESET = 3'h0;
   localparam logic        RSS_RESET  = 1'b0;
   localparam logic [23:0] SP_RESET   = 24'h000000;
endpackage

// File: brfsp_regfile.sv
// Summary of operation
// - 24-bit stack pointer, loaded and stepped only through dedicated strobes.
// - push decrements then stores; pop loads then increments.
// - nmi push proceeds with whatever value the stack pointer holds.
// - each bank has sixteen bytes; adjacent bytes pair into 16-bit registers.
// - four pairs plus an extension byte form readable writable 24-bit pointers.
// - byte registers live in ram; the four extension bytes are held apart.
// - eight banks, switched by instruction or by context switch.
// - reset selects bank 0; bank bits always readable in the status word.
// - register window aliases the register ram of all banks, moving up with high mapping.
// - high mapping shifts every register ram address up by 0f0000h.
// - interrupt accept pushes status word with bank bits; returns restore it.
// - context switch saves pc low 16 bits in new bank's saved-pc-low pair.
// - context switch saves pc top 4 bits and status word, minus status bits 8-11.
// - legacy select 1 maps accumulator, index, counter roles onto r4-r7, rp2, rp3.
// - wide accumulator with offset pair one forms the 32-bit quad accumulator.
// - loop count and counter registers both serve decrement-and-branch.
// - counter is string element count; two string pointers give the addresses.
// - user stack register is a separate stack pointer for user push and pop.
// - offset pairs, accumulator and loop count supply indexed offsets.
// - bank bits are plain binary, value n selects bank n.
//
// The register addresses and the plain strobed port were decided locally.
module brfsp_regfile (
   // clock and reset
   input  wire  logic                             clk,
   input  wire  logic                             arst_n,
   // memory mapping option
   input  wire  logic                             high_mem_map,
   // absolute byte access
   input  wire  logic                             byte_wr,
   input  wire  logic [brfsp_pkg::REG_W-1:0]      byte_idx,
   input  wire  logic [7:0]                       byte_wdata,
   output logic       [7:0]                       byte_rdata,
   // absolute pair access
   input  wire  logic                             pair_wr,
   input  wire  logic [2:0]                       pair_idx,
   input  wire  logic [15:0]                      pair_wdata,
   output logic       [15:0]                      pair_rdata,
   // 24-bit pointer access
   input  wire  logic                             ptr_wr,
   input  wire  logic [1:0]                       ptr_idx,
   input  wire  logic [23:0]                      ptr_wdata,
   output logic       [23:0]                      ptr_rdata,
   // quad accumulator write
   input  wire  logic                             quad_wr,
   input  wire  logic [31:0]                      quad_wdata,
   // system stack
   input  wire  logic                             sp_load,
   input  wire  logic [23:0]                      sp_wdata,
   input  wire  logic                             sp_push,
   input  wire  logic                             sp_pop,
   input  wire  logic [2:0]                       sp_step,
   output logic       [23:0]                      stack_pointer,
   // user stack
   input  wire  logic                             ustk_push,
   input  wire  logic                             ustk_pop,
   input  wire  logic [2:0]                       ustk_step,
   // bank and status word control
   input  wire  logic                             bank_switch_op,
   input  wire  logic [brfsp_pkg::BANK_W-1:0]     bank_switch_val,
   input  wire  logic                             rss_wr,
   input  wire  logic                             rss_wdata,
   input  wire  logic                             psw_restore,
   input  wire  logic [15:0]                      psw_restore_data,
   input  wire  logic [15:0]                      psw_other_bits,
   output logic       [15:0]                      program_status_word,
   output logic       [brfsp_pkg::BANK_W-1:0]     bank_select_bits,
   output logic                                   legacy_set_select,
   // context switch
   input  wire  logic                             ctx_switch,
   input  wire  logic [brfsp_pkg::BANK_W-1:0]     ctx_bank,
   input  wire  logic [19:0]                      ctx_pc,
   // decrement and branch
   input  wire  logic                             decrement_branch_loop,
   input  wire  logic                             dbl_use_counter,
   output logic                                   dbl_nonzero,
   // data memory alias port
   input  wire  logic                             mem_wr,
   input  wire  logic                             mem_rd,
   input  wire  logic [brfsp_pkg::ADDR_W-1:0]     mem_addr,
   input  wire  logic [7:0]                       mem_wdata,
   output logic       [7:0]                       mem_rdata,
   output logic                                   mem_hit,
   // role views
   output logic       [7:0]                       acc_reg,
   output logic       [7:0]                       index_reg,
   output logic       [7:0]                       counter_reg,
   output logic       [7:0]                       loop_count_reg,
   output logic       [15:0]                      wide_accumulator,
   output logic       [15:0]                      counter_pair,
   output logic       [15:0]                      offset_pair_one,
   output logic       [15:0]                      offset_pair_two,
   output logic       [31:0]                      quad_accumulator,
   output logic       [23:0]                      base_pointer_register,
   output logic       [23:0]                      user_stack_register,
   output logic       [23:0]                      string_pointer_one,
   output logic       [23:0]                      string_pointer_two
);
   import brfsp_pkg::*;

   localparam int RAM_DEPTH = NUM_BANKS * REGS_PER_BANK;

   logic [7:0]          ram_ff [RAM_DEPTH];
   logic [7:0]          ext_ff [NUM_BANKS * 4];
   logic [2:0]          bank_ff;
   logic [2:0]          nxt_bank;
   logic                rss_ff;
   logic                nxt_rss;
   logic [23:0]         sp_ff;
   logic [23:0]         nxt_sp;
   logic [15:0]         psw_view;
   logic [3:0]          role_shift;
   logic [23:0]         win_base;
   logic                win_hit;
   logic [3:0]          dbl_reg;
   logic [7:0]          dbl_result;
   logic [23:0]         ustk_cur;
   logic [23:0]         ustk_new;
   logic [15:0]         ctx_save_hi;

   function automatic logic [6:0] slot(input logic [2:0] bank, input logic [3:0] r);
      slot = {bank, r};
   endfunction

   function automatic logic [4:0] eslot(input logic [2:0] bank, input logic [1:0] k);
      eslot = {bank, k};
   endfunction

   // bank, legacy select and status word
   always_comb begin
      nxt_bank = bank_ff;
      nxt_rss  = rss_ff;
      if (bank_switch_op) begin
         nxt_bank = bank_switch_val;
      end
      if (rss_wr) begin
         nxt_rss = rss_wdata;
      end
      if (psw_restore) begin
         nxt_bank = psw_restore_data[PSW_BANK_MSB:PSW_BANK_LSB];
         nxt_rss  = psw_restore_data[PSW_RSS_BIT];
      end
      if (ctx_switch) begin
         nxt_bank = ctx_bank;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bank_ff <= BANK_RESET;
         rss_ff  <= RSS_RESET;
      end else begin
         bank_ff <= nxt_bank;
         rss_ff  <= nxt_rss;
      end
   end

   always_comb begin
      psw_view = psw_other_bits;
      psw_view[PSW_BANK_MSB:PSW_BANK_LSB] = bank_ff;
      psw_view[PSW_RSS_BIT] = rss_ff;
   end

   assign bank_select_bits  = bank_ff;
   assign legacy_set_select = rss_ff;
   // vectored interrupt pushes this word; bank bits ride along
   assign program_status_word = psw_view;

   // system stack pointer; reset only gives a known value, software must load it
   always_comb begin
      nxt_sp = sp_ff;
      if (sp_load) begin
         nxt_sp = sp_wdata;
      end else if (sp_push) begin
         nxt_sp = sp_ff - {21'h000000, sp_step};
      end else if (sp_pop) begin
         nxt_sp = sp_ff + {21'h000000, sp_step};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sp_ff <= SP_RESET;
      end else begin
         sp_ff <= nxt_sp;
      end
   end

   // after push, stack_pointer is the address of the stored data
   assign stack_pointer = sp_ff;

   // role remapping for legacy programs
   assign role_shift = rss_ff ? LEGACY_SHIFT : 4'h0;

   // memory alias window
   assign win_base = high_mem_map ? (GPR_WINDOW_BASE + HIGH_MAP_OFFSET) : GPR_WINDOW_BASE;
   assign win_hit  = (mem_addr[ADDR_W-1:WINDOW_LSB_W] == win_base[ADDR_W-1:WINDOW_LSB_W]);

   // decrement and branch counter choice
   assign dbl_reg    = (dbl_use_counter ? REG_C : REG_B) + role_shift;
   assign dbl_result = ram_ff[slot(bank_ff, dbl_reg)] - 8'h01;

   // user stack pointer value and its stepped value
   assign ustk_cur = {ext_ff[eslot(bank_ff, PTR_USTACK)],
                      ram_ff[slot(bank_ff, 4'hb)], ram_ff[slot(bank_ff, 4'ha)]};
   assign ustk_new = ustk_push ? (ustk_cur - {21'h000000, ustk_step})
                               : (ustk_cur + {21'h000000, ustk_step});

   // saved-pc-high pair: status high nibble, pc top bits, status low byte
   assign ctx_save_hi = {psw_view[15:PSW_SAVE_HI_LSB], ctx_pc[19:16], psw_view[PSW_SAVE_LO_MSB:0]};

   // ram writes; later statements win when two paths hit one byte
   always_ff @(posedge clk) begin
      if (mem_wr && win_hit) begin
         ram_ff[mem_addr[RAM_IDX_W-1:0]] <= mem_wdata;
      end
      if (byte_wr) begin
         ram_ff[slot(bank_ff, byte_idx)] <= byte_wdata;
      end
      if (pair_wr) begin
         ram_ff[slot(bank_ff, {pair_idx, 1'b0})] <= pair_wdata[7:0];
         ram_ff[slot(bank_ff, {pair_idx, 1'b1})] <= pair_wdata[15:8];
      end
      if (ptr_wr) begin
         ram_ff[slot(bank_ff, {1'b1, ptr_idx, 1'b0})] <= ptr_wdata[7:0];
         ram_ff[slot(bank_ff, {1'b1, ptr_idx, 1'b1})] <= ptr_wdata[15:8];
      end
      if (ustk_push || ustk_pop) begin
         ram_ff[slot(bank_ff, 4'ha)] <= ustk_new[7:0];
         ram_ff[slot(bank_ff, 4'hb)] <= ustk_new[15:8];
      end
      if (quad_wr) begin
         ram_ff[slot(bank_ff, REG_E)]                  <= quad_wdata[7:0];
         ram_ff[slot(bank_ff, REG_E + 4'h1)]           <= quad_wdata[15:8];
         ram_ff[slot(bank_ff, REG_X + role_shift)]     <= quad_wdata[23:16];
         ram_ff[slot(bank_ff, REG_A + role_shift)]     <= quad_wdata[31:24];
      end
      if (decrement_branch_loop) begin
         ram_ff[slot(bank_ff, dbl_reg)] <= dbl_result;
      end
      if (ctx_switch) begin
         ram_ff[slot(ctx_bank, {PAIR_PC_LOW, 1'b0})]  <= ctx_pc[7:0];
         ram_ff[slot(ctx_bank, {PAIR_PC_LOW, 1'b1})]  <= ctx_pc[15:8];
         ram_ff[slot(ctx_bank, {PAIR_PC_HIGH, 1'b0})] <= ctx_save_hi[7:0];
         ram_ff[slot(ctx_bank, {PAIR_PC_HIGH, 1'b1})] <= ctx_save_hi[15:8];
      end
   end

   // extension bytes sit outside the memory window
   always_ff @(posedge clk) begin
      if (ptr_wr) begin
         ext_ff[eslot(bank_ff, ptr_idx)] <= ptr_wdata[23:16];
      end
      if (ustk_push || ustk_pop) begin
         ext_ff[eslot(bank_ff, PTR_USTACK)] <= ustk_new[23:16];
      end
   end

   // handshake-free status from the decrement
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dbl_nonzero <= 1'b0;
      end else begin
         dbl_nonzero <= decrement_branch_loop && (dbl_result != 8'h00);
      end
   end

   // memory reads see register writes of earlier cycles, same byte
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_rdata <= 8'h00;
         mem_hit   <= 1'b0;
      end else begin
         mem_hit   <= (mem_rd || mem_wr) && win_hit;
         mem_rdata <= (mem_rd && win_hit) ? ram_ff[mem_addr[RAM_IDX_W-1:0]] : 8'h00;
      end
   end

   // absolute read ports, one cycle latency
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         byte_rdata <= 8'h00;
         pair_rdata <= 16'h0000;
         ptr_rdata  <= 24'h000000;
      end else begin
         byte_rdata <= ram_ff[slot(bank_ff, byte_idx)];
         pair_rdata <= {ram_ff[slot(bank_ff, {pair_idx, 1'b1})],
                        ram_ff[slot(bank_ff, {pair_idx, 1'b0})]};
         ptr_rdata  <= {ext_ff[eslot(bank_ff, ptr_idx)],
                        ram_ff[slot(bank_ff, {1'b1, ptr_idx, 1'b1})],
                        ram_ff[slot(bank_ff, {1'b1, ptr_idx, 1'b0})]};
      end
   end

   // role views of the active bank, registered
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_reg          <= 8'h00;
         index_reg        <= 8'h00;
         counter_reg      <= 8'h00;
         loop_count_reg   <= 8'h00;
         wide_accumulator <= 16'h0000;
         counter_pair     <= 16'h0000;
         offset_pair_one  <= 16'h0000;
         offset_pair_two  <= 16'h0000;
         quad_accumulator <= 32'h00000000;
      end else begin
         acc_reg          <= ram_ff[slot(bank_ff, REG_A + role_shift)];
         index_reg        <= ram_ff[slot(bank_ff, REG_X + role_shift)];
         counter_reg      <= ram_ff[slot(bank_ff, REG_C + role_shift)];
         loop_count_reg   <= ram_ff[slot(bank_ff, REG_B + role_shift)];
         wide_accumulator <= {ram_ff[slot(bank_ff, REG_A + role_shift)],
                              ram_ff[slot(bank_ff, REG_X + role_shift)]};
         counter_pair     <= {ram_ff[slot(bank_ff, REG_B + role_shift)],
                              ram_ff[slot(bank_ff, REG_C + role_shift)]};
         offset_pair_one  <= {ram_ff[slot(bank_ff, {PAIR_DE, 1'b1})],
                              ram_ff[slot(bank_ff, {PAIR_DE, 1'b0})]};
         offset_pair_two  <= {ram_ff[slot(bank_ff, {PAIR_HL, 1'b1})],
                              ram_ff[slot(bank_ff, {PAIR_HL, 1'b0})]};
         quad_accumulator <= {ram_ff[slot(bank_ff, REG_A + role_shift)],
                              ram_ff[slot(bank_ff, REG_X + role_shift)],
                              ram_ff[slot(bank_ff, REG_E + 4'h1)],
                              ram_ff[slot(bank_ff, REG_E)]};
      end
   end

   // the four 24-bit pointers, one generate entry each
   logic [23:0] ptr_view [4];
   for (genvar k = 0; k < 4; k++) begin : g_ptr
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            ptr_view[k] <= 24'h000000;
         end else begin
            ptr_view[k] <= {ext_ff[eslot(bank_ff, 2'(k))],
                            ram_ff[slot(bank_ff, {1'b1, 2'(k), 1'b1})],
                            ram_ff[slot(bank_ff, {1'b1, 2'(k), 1'b0})]};
         end
      end
   end

   assign base_pointer_register = ptr_view[PTR_BASE];
   assign user_stack_register   = ptr_view[PTR_USTACK];
   assign string_pointer_one    = ptr_view[PTR_STR_ONE];
   assign string_pointer_two    = ptr_view[PTR_STR_TWO];
endmodule

// File: brfsp_exec_model.sv
module brfsp_exec_model #(
   parameter logic [23:0] STACK_TOP  = 24'h00fee0,
   parameter logic [15:0] OTHER_BITS = 16'h8b53
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // startup stack load
   output logic             sp_load,
   output logic [23:0]      sp_wdata,
   // rest of the status word
   output logic [15:0]      psw_other_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   logic load_ff;
   logic done_ff;
   logic [23:0] top;
   // top nibble forced clear, stack kept below 100000h
   assign top = {4'h0, STACK_TOP[19:0]};
   assign sp_load = load_ff;
   // no stale value on the data lines outside the load
   assign sp_wdata = load_ff ? top : ~top;
   assign psw_other_bits = OTHER_BITS;
   // one load right after every reset release, before any call
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         load_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         load_ff <= !done_ff;
         done_ff <= 1'b1;
      end
   end
endmodule

// File: brfsp_regfile_assertions.sv
module brfsp_regfile_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // stack
   input wire logic        sp_load,
   input wire logic [23:0] sp_wdata,
   input wire logic        sp_push,
   input wire logic        sp_pop,
   input wire logic [2:0]  sp_step,
   input wire logic [23:0] stack_pointer,
   // bank and status
   input wire logic        bank_switch_op,
   input wire logic [2:0]  bank_switch_val,
   input wire logic        psw_restore,
   input wire logic [15:0] psw_restore_data,
   input wire logic [15:0] psw_other_bits,
   input wire logic [15:0] program_status_word,
   input wire logic [2:0]  bank_select_bits,
   input wire logic        legacy_set_select,
   input wire logic        ctx_switch,
   input wire logic [2:0]  ctx_bank
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rdat_ff;
   always_ff @(posedge clk) begin
      rdat_ff <= psw_restore_data;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   AST_SP_LOAD: assert property (sp_load |=> stack_pointer == $past(sp_wdata))
      else $error("stack pointer load lost");
   AST_SP_PUSH: assert property (sp_push && !sp_load |=>
      stack_pointer == $past(stack_pointer) - {21'h0, $past(sp_step)}) else $error("push step wrong");
   AST_SP_POP: assert property (sp_pop && !sp_push && !sp_load |=>
      stack_pointer == $past(stack_pointer) + {21'h0, $past(sp_step)}) else $error("pop step wrong");
   AST_SP_HOLD: assert property (!(sp_load || sp_push || sp_pop) |=> $stable(stack_pointer))
      else $error("stack pointer moved");
   AST_CTX_BANK: assert property (ctx_switch |=> bank_select_bits == $past(ctx_bank))
      else $error("context switch bank wrong");
   AST_SEL_BANK: assert property (bank_switch_op && !ctx_switch && !psw_restore |=>
      bank_select_bits == $past(bank_switch_val)) else $error("bank select wrong");
   AST_RESTORE: assert property (psw_restore && !ctx_switch |=>
      bank_select_bits == rdat_ff[14:12] && legacy_set_select == rdat_ff[5]) else $error("restore wrong");
   AST_PSW_VIEW: assert property (program_status_word == {psw_other_bits[15], bank_select_bits,
      psw_other_bits[11:6], legacy_set_select, psw_other_bits[4:0]}) else $error("status word view wrong");
   AST_RESET: assert property ($rose(arst_n) |-> bank_select_bits == 3'h0 && !legacy_set_select)
      else $error("reset bank not zero");
   cover property (sp_push);
   cover property (ctx_switch);
   cover property (bank_switch_op && bank_switch_val == 3'h7);
endmodule

bind brfsp_regfile brfsp_regfile_checker u_brfsp_regfile_checker (.*);

// File: brfsp_regfile_bench.sv
module brfsp_regfile_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import brfsp_pkg::*;
   localparam logic [23:0] TOP = 24'h00fee0;
   logic        clk, arst_n, high_mem_map, byte_wr, pair_wr, ptr_wr, quad_wr, sp_load, sp_push, sp_pop;
   logic        ustk_push, ustk_pop, bank_switch_op, rss_wr, rss_wdata, psw_restore, ctx_switch, mem_hit;
   logic        decrement_branch_loop, dbl_use_counter, dbl_nonzero, mem_wr, mem_rd, legacy_set_select, rs;
   logic [2:0]  pair_idx, sp_step, ustk_step, bank_switch_val, ctx_bank, bank_select_bits, bk;
   logic [1:0]  ptr_idx;
   logic [3:0]  byte_idx;
   logic [7:0]  byte_wdata, byte_rdata, mem_wdata, mem_rdata, acc_reg, index_reg, counter_reg, loop_count_reg;
   logic [15:0] pair_wdata, pair_rdata, psw_restore_data, psw_other_bits, program_status_word, w;
   logic [15:0] wide_accumulator, counter_pair, offset_pair_one, offset_pair_two;
   logic [19:0] ctx_pc;
   logic [23:0] ptr_wdata, ptr_rdata, sp_wdata, stack_pointer, mem_addr, base_pointer_register;
   logic [23:0] user_stack_register, string_pointer_one, string_pointer_two, pv[4];
   logic [31:0] quad_wdata, quad_accumulator, q;
   int          n_mismatch, cmp_count, cyc, s, v, sp;
   int          rm[8][16];

   brfsp_regfile u_brfsp_regfile (.*);
   brfsp_exec_model #(.STACK_TOP(TOP)) u_brfsp_exec_model (.*);

   always #5 clk = ~clk;
   // generous ceiling, the run needs under two hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // drop every strobe, then let results settle
   task go(input int n);
      @(posedge clk);
      {byte_wr, ptr_wr, quad_wr, sp_push, sp_pop, ustk_push, bank_switch_op, rss_wr} <= '0;
      {psw_restore, ctx_switch, decrement_branch_loop, mem_wr, mem_rd, ustk_pop, pair_wr} <= '0;
      repeat (n - 1) @(posedge clk);
      #1;
   endtask
   task wb(input int r, input logic [7:0] d);
      @(posedge clk);
      byte_wr <= 1'b1;
      byte_idx <= 4'(r);
      byte_wdata <= d;
      rm[bk][r] = d;
      go(2);
   endtask
   task mr(input logic [23:0] a);
      @(posedge clk);
      mem_rd <= 1'b1;
      mem_addr <= a;
      go(1);
   endtask
   function automatic logic [15:0] psw_exp();
      return {psw_other_bits[15], bk, psw_other_bits[11:6], rs, psw_other_bits[4:0]};
   endfunction

   initial begin
      clk = 0;
      {arst_n, high_mem_map, byte_wr, pair_wr, ptr_wr, quad_wr, sp_push, sp_pop, ustk_push, ustk_pop} = '0;
      {bank_switch_op, rss_wr, rss_wdata, psw_restore, ctx_switch, decrement_branch_loop, dbl_use_counter} = '0;
      {mem_wr, mem_rd, byte_idx, byte_wdata, pair_idx, pair_wdata, ptr_idx, ptr_wdata, quad_wdata} = '0;
      {sp_step, ustk_step, bank_switch_val, psw_restore_data, ctx_bank, ctx_pc, mem_addr, mem_wdata} = '0;
      s = $urandom(32'he6da);
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      bk = 3'h0;
      rs = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(program_status_word, psw_exp());
      chk(stack_pointer, TOP);
      sp = TOP;
      for (int i = 0; i < 8; i++) begin
         s = $urandom_range(7, 1);
         @(posedge clk);
         sp_step <= 3'(s);
         if (i % 2 == 1) sp_pop <= 1'b1;
         else sp_push <= 1'b1;
         sp = (i % 2 == 1) ? sp + s : sp - s;
         go(1);
         chk(stack_pointer, sp);
      end
      $display("test stack done");
      for (int n = 0; n < 8; n++) begin
         @(posedge clk);
         bank_switch_op <= 1'b1;
         bank_switch_val <= 3'(n);
         bk = 3'(n);
         go(1);
         chk(program_status_word, psw_exp());
         v = $urandom_range(15, 0);
         wb(v, 8'($urandom));
         chk(byte_rdata, rm[bk][v]);
         mr(GPR_WINDOW_BASE + 24'(n * 16 + v));
         chk({mem_hit, mem_rdata}, {1'b1, 8'(rm[bk][v])});
         @(posedge clk);
         mem_wr <= 1'b1;
         mem_addr <= GPR_WINDOW_BASE + 24'(n * 16 + (v ^ 1));
         mem_wdata <= 8'(n + 8'h30);
         byte_idx <= 4'(v ^ 1);
         go(2);
         chk(byte_rdata, 8'(n + 8'h30));
      end
      @(posedge clk);
      high_mem_map <= 1'b1;
      mr(GPR_WINDOW_BASE + 24'(7 * 16 + v));
      chk({mem_hit, mem_rdata}, 9'h0);
      mr(GPR_WINDOW_BASE + HIGH_MAP_OFFSET + 24'(7 * 16 + v));
      chk({mem_hit, mem_rdata}, {1'b1, 8'(rm[7][v])});
      $display("test banks done");
      for (int k = 0; k < 4; k++) begin
         pv[k] = 24'($urandom);
         @(posedge clk);
         ptr_wr <= 1'b1;
         ptr_idx <= 2'(k);
         ptr_wdata <= pv[k];
         pair_idx <= 3'(4 + k);
         go(2);
         chk(ptr_rdata, pv[k]);
         chk(pair_rdata, pv[k][15:0]);
      end
      chk(base_pointer_register, pv[0]);
      chk(string_pointer_one, pv[2]);
      chk(string_pointer_two, pv[3]);
      @(posedge clk);
      pair_wr <= 1'b1;
      pair_idx <= 3'h7;
      pair_wdata <= 16'($urandom);
      go(2);
      chk(pair_rdata, pair_wdata);
      chk(offset_pair_two, pair_wdata);
      @(posedge clk);
      ustk_push <= 1'b1;
      ustk_step <= 3'h5;
      go(2);
      chk(user_stack_register, 24'(pv[1] - 24'h5));
      @(posedge clk);
      ustk_pop <= 1'b1;
      ustk_step <= 3'h3;
      go(2);
      chk(user_stack_register, 24'(pv[1] - 24'h2));
      q = $urandom;
      @(posedge clk);
      quad_wr <= 1'b1;
      quad_wdata <= q;
      go(2);
      chk(quad_accumulator, q);
      chk(offset_pair_one, q[15:0]);
      chk({wide_accumulator, index_reg}, {q[31:16], q[23:16]});
      $display("test pointers done");
      @(posedge clk);
      rss_wr <= 1'b1;
      rss_wdata <= 1'b1;
      rs = 1'b1;
      go(2);
      chk(program_status_word, psw_exp());
      chk(legacy_set_select, rs);
      wb(5, 8'h5a);
      chk(acc_reg, 8'h5a);
      // loop count one reports zero then wraps; counter two steps to one, then zero
      wb(7, 8'h01);
      wb(6, 8'h02);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         decrement_branch_loop <= 1'b1;
         dbl_use_counter <= (i >= 2);
         go(1);
         chk(dbl_nonzero, 1'(i == 1 || i == 2));
      end
      chk({loop_count_reg, counter_reg}, {8'hff, 8'h01});
      chk(counter_pair, 16'hff01);
      @(posedge clk);
      psw_restore <= 1'b1;
      psw_restore_data <= 16'h5000;
      bk = 3'h5;
      rs = 1'b0;
      go(1);
      chk(program_status_word, psw_exp());
      $display("test roles done");
      w = psw_exp();
      @(posedge clk);
      ctx_pc <= 20'($urandom);
      ctx_switch <= 1'b1;
      ctx_bank <= 3'h2;
      pair_idx <= PAIR_PC_LOW;
      bk = 3'h2;
      go(2);
      chk(bank_select_bits, bk);
      chk(pair_rdata, ctx_pc[15:0]);
      @(posedge clk);
      pair_idx <= PAIR_PC_HIGH;
      go(2);
      chk(pair_rdata, {w[15:12], ctx_pc[19:16], w[7:0]});
      $display("test context done");
      stop_test();
   end
endmodule
